// ===== verilog/grs_defines.svh
`ifndef GRS_DEFINES_SVH
`define GRS_DEFINES_SVH

// Register indices on the plain register port
`define GRS_A_CTRL 4'h0
`define GRS_A_STB 4'h1
`define GRS_A_SRE 4'h2
`define GRS_A_COND0 4'h3
`define GRS_A_EVENT0 4'h4
`define GRS_A_ENABLE0 4'h8
`define GRS_A_OUTQ 4'hc
`define GRS_A_ERRQ 4'hd
`define GRS_A_STATE 4'he
`define GRS_A_CMD 4'hf

// Status byte bit positions
`define GRS_SB_EAV 2
`define GRS_SB_MAV 4
`define GRS_SB_RQS 6

// Command code bit positions in the command register
`define GRS_CMD_CLS 0
`define GRS_CMD_PRESET 1

// Control register fields
`define GRS_CTRL_BUSTRIG 0

// Reset values
`define GRS_RST_BYTE 8'h00

// Queue depths
`define GRS_ERRQ_DEPTH 10
`define GRS_OUTQ_DEPTH 16

`endif

// ===== verilog/grs_pkg.sv
package grs_pkg;

	typedef enum logic [1:0] {
		GRS_LOCAL = 2'b00,
		GRS_REMOTE = 2'b01,
		GRS_LOCKED_REMOTE = 2'b11,
		GRS_LOCKED_LOCAL = 2'b10
	} grs_rl_t;

	// Decoded bus messages from the interface front end, one-cycle pulses
	typedef struct packed {
		logic my_talk;
		logic my_listen;
		logic untalk;
		logic unlisten;
		logic ifc;
		logic llo;
		logic gtl;
		logic dcl;
		logic sdc;
		logic get;
		logic spoll_read;
	} grs_bus_msg_t;

	typedef struct packed {
		logic remote;
		logic lockout;
		logic talk;
		logic listen;
		logic srq;
	} grs_ind_t;

endpackage : grs_pkg

// ===== verilog/grs_fifo.sv
`include "grs_defines.svh"

module grs_fifo
	import grs_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 10
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Write side
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	output logic full,
	// Read side
	input wire logic pop,
	output logic [WIDTH-1:0] pop_data,
	output logic empty,
	// Flush
	input wire logic flush
);

	localparam int AW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || WIDTH < 1)
			$error("grs_fifo: DEPTH must be at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_push;
	logic do_pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction : bump

	assign full = (count == (AW+1)'(DEPTH));
	assign empty = (count == '0);
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	assign pop_data = mem[rd_ptr];

	always_ff @(posedge clock) begin
		if (do_push)
			mem[wr_ptr] <= push_data;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push)
				wr_ptr <= bump(wr_ptr);
			if (do_pop)
				rd_ptr <= bump(rd_ptr);
			if (do_push && !do_pop)
				count <= count + (AW+1)'(1);
			else if (do_pop && !do_push)
				count <= count - (AW+1)'(1);
		end
	end

endmodule : grs_fifo

// ===== verilog/grs_remote_status.sv
// Summary of operation
// - Lockout disables all panel keys and LOCAL
// - Go-to-local leaves remote and ends lockout
// - Universal clear acts even when unaddressed
// - Clear flushes input, output queue, deferred
// - Clear keeps configuration and stored data
// - Selective clear only when addressed listener
// - Trigger only if listener and bus source
// - Serial poll returns status byte, bit6 request
// - Remote only when listen-addressed with enable
// - In remote only LOCAL key works
// - Talk address on; untalk/listen/IFC off
// - Listen address on; unlisten/talk/IFC off
// - Request lamp lit until polled, clear-status or causes gone
// - LOCAL key cancels remote unless locked out
// - Condition registers read-only, track live inputs
// - Event bits latch from condition bits
// - Event AND enable, ORed into status byte
// - Event read clears; clear-status clears all
// - Enable zero masks the event bit
// - Enables survive reads; preset clears three
// - Output queue and error queue FIFOs
// - Four register sets feed status byte
// - Message available follows output queue occupancy
// - Error queue ten deep, error available flag
// - Poll clears request, summary stays set
// - Enabled summary rising sets request and SRQ
`include "grs_defines.svh"

module grs_remote_status
	import grs_pkg::*;
#(
	parameter int NSETS = 4,
	parameter int OUTQ_DEPTH = `GRS_OUTQ_DEPTH,
	parameter int ERRQ_DEPTH = `GRS_ERRQ_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Decoded bus messages and lines
	input wire grs_bus_msg_t bus_msg,
	input wire logic ren_line,
	output logic srq_line,
	output logic [7:0] poll_byte,
	// Front panel
	input wire logic local_key,
	input wire logic [7:0] panel_keys,
	output logic [7:0] panel_keys_live,
	output grs_ind_t ind,
	output logic remote_state_indicator,
	output logic listener_active_indicator,
	output logic display_restore,
	// Instrument side
	input wire logic [8*NSETS-1:0] cond_in,
	output logic trigger,
	output logic input_flush,
	output logic deferred_cancel,
	input wire logic resp_push,
	input wire logic [7:0] resp_data,
	output logic resp_full,
	input wire logic err_push,
	input wire logic [7:0] err_data,
	output logic err_full,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);

	initial begin
		if (NSETS != 4)
			$error("grs_remote_status: exactly four register sets supported");
	end

	grs_rl_t rl;
	logic talk_act;
	logic listen_act;
	logic [7:0] ctrl;
	logic [7:0] sre;
	logic [7:0] event_r [NSETS];
	logic [7:0] enable_r [NSETS];
	logic [7:0] cond_q [NSETS];
	logic [NSETS-1:0] summary;
	logic [7:0] stb;
	logic mss;
	logic [7:0] srq_src;
	logic [7:0] srq_src_q;
	logic rqs;
	logic srq_lamp;
	logic dev_clear;
	logic cls;
	logic preset;
	logic outq_empty;
	logic errq_empty;
	logic [7:0] outq_data;
	logic [7:0] errq_data;
	logic outq_pop;
	logic errq_pop;
	logic [7:0] next_rdata;

	function automatic logic is_event_addr(input logic [3:0] a, input int i);
		is_event_addr = (a == 4'(`GRS_A_EVENT0 + i));
	endfunction : is_event_addr

	function automatic logic is_enable_addr(input logic [3:0] a, input int i);
		is_enable_addr = (a == 4'(`GRS_A_ENABLE0 + i));
	endfunction : is_enable_addr

	assign cls = wr && addr == `GRS_A_CMD && wdata[`GRS_CMD_CLS];
	assign preset = wr && addr == `GRS_A_CMD && wdata[`GRS_CMD_PRESET];
	// Universal clear needs no address, selective needs listener state
	assign dev_clear = bus_msg.dcl || (bus_msg.sdc && listen_act);
	assign input_flush = dev_clear;
	assign deferred_cancel = dev_clear;

	// Remote/local with lockout
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rl <= GRS_LOCAL;
		end else if (bus_msg.gtl && listen_act) begin
			rl <= GRS_LOCAL;
		end else if (!ren_line) begin
			rl <= GRS_LOCAL;
		end else begin
			unique case (rl)
				GRS_LOCAL: begin
					if (bus_msg.llo)
						rl <= GRS_LOCKED_LOCAL;
					else if (bus_msg.my_listen)
						rl <= GRS_REMOTE;
				end
				GRS_REMOTE: begin
					if (bus_msg.llo)
						rl <= GRS_LOCKED_REMOTE;
					else if (local_key)
						rl <= GRS_LOCAL;
				end
				GRS_LOCKED_REMOTE: begin
					rl <= GRS_LOCKED_REMOTE;
				end
				GRS_LOCKED_LOCAL: begin
					if (bus_msg.my_listen)
						rl <= GRS_LOCKED_REMOTE;
				end
			endcase
		end
	end

	// Talker and listener addressing
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			talk_act <= 1'b0;
		end else if (bus_msg.ifc || bus_msg.untalk || bus_msg.my_listen) begin
			talk_act <= 1'b0;
		end else if (bus_msg.my_talk) begin
			talk_act <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			listen_act <= 1'b0;
		end else if (bus_msg.ifc || bus_msg.unlisten || bus_msg.my_talk) begin
			listen_act <= 1'b0;
		end else if (bus_msg.my_listen) begin
			listen_act <= 1'b1;
		end
	end

	// Trigger gated by listener state and source selection
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			trigger <= 1'b0;
		else
			trigger <= bus_msg.get && listen_act && ctrl[`GRS_CTRL_BUSTRIG];
	end

	// Panel: remote blocks all but LOCAL, lockout blocks everything
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			panel_keys_live <= 8'h00;
			display_restore <= 1'b0;
		end else begin
			panel_keys_live <= (rl == GRS_LOCAL) ? panel_keys : 8'h00;
			display_restore <= local_key && rl == GRS_REMOTE && ren_line;
		end
	end

	assign remote_state_indicator = rl[0];
	assign listener_active_indicator = listen_act;
	assign ind = '{remote: rl[0], lockout: rl[1], talk: talk_act,
		listen: listen_act, srq: srq_lamp};

	// Control and service request enable registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl <= `GRS_RST_BYTE;
			sre <= `GRS_RST_BYTE;
		end else if (wr) begin
			if (addr == `GRS_A_CTRL)
				ctrl <= wdata;
			if (addr == `GRS_A_SRE)
				sre <= wdata;
		end
	end

	// Condition, event and enable register sets
	for (genvar i = 0; i < NSETS; i++) begin : g_set
		always_ff @(posedge clock or posedge rst) begin
			if (rst)
				cond_q[i] <= 8'h00;
			else
				cond_q[i] <= cond_in[8*i +: 8];
		end

		// A new condition on the clearing cycle still latches
		always_ff @(posedge clock or posedge rst) begin
			if (rst)
				event_r[i] <= 8'h00;
			else if (cls || (rd && is_event_addr(addr, i)))
				event_r[i] <= cond_in[8*i +: 8] & ~cond_q[i];
			else
				event_r[i] <= event_r[i] | (cond_in[8*i +: 8] & ~cond_q[i]);
		end

		// Set 0 is standard event; write zero clears it, preset spares it
		always_ff @(posedge clock or posedge rst) begin
			if (rst)
				enable_r[i] <= 8'h00;
			else if (wr && is_enable_addr(addr, i))
				enable_r[i] <= wdata;
			else if (preset && i != 0)
				enable_r[i] <= 8'h00;
		end

		assign summary[i] = |(event_r[i] & enable_r[i]);
	end

	// Status byte: sets on bits 0,3,5,7; queues on 2 and 4
	always_comb begin
		stb = 8'h00;
		stb[0] = summary[1];
		stb[3] = summary[2];
		stb[5] = summary[0];
		stb[7] = summary[3];
		stb[`GRS_SB_EAV] = !errq_empty;
		stb[`GRS_SB_MAV] = !outq_empty;
	end

	// Per-bit edges so a second source can raise a new request while MSS stands
	assign srq_src = stb & sre & 8'hbf;
	assign mss = |srq_src;

	// Request for service and SRQ lamp
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			srq_src_q <= 8'h00;
			rqs <= 1'b0;
		end else begin
			srq_src_q <= srq_src;
			if (|(srq_src & ~srq_src_q))
				rqs <= 1'b1;
			else if (bus_msg.spoll_read || !mss || cls)
				rqs <= 1'b0;
		end
	end

	assign srq_lamp = rqs;
	assign srq_line = rqs;

	// Poll byte always available; bit 6 reports the request
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			poll_byte <= 8'h00;
		else
			poll_byte <= (stb & 8'hbf) | {1'b0, rqs, 6'h00};
	end

	// Queues
	assign outq_pop = rd && addr == `GRS_A_OUTQ;
	assign errq_pop = rd && addr == `GRS_A_ERRQ;

	grs_fifo #(
		.WIDTH(8),
		.DEPTH(OUTQ_DEPTH)
	) u_outq (
		.clock(clock),
		.rst(rst),
		.push(resp_push),
		.push_data(resp_data),
		.full(resp_full),
		.pop(outq_pop),
		.pop_data(outq_data),
		.empty(outq_empty),
		.flush(dev_clear)
	);

	grs_fifo #(
		.WIDTH(8),
		.DEPTH(ERRQ_DEPTH)
	) u_errq (
		.clock(clock),
		.rst(rst),
		.push(err_push),
		.push_data(err_data),
		.full(err_full),
		.pop(errq_pop),
		.pop_data(errq_data),
		.empty(errq_empty),
		.flush(cls)
	);

	// Register read mux
	always_comb begin
		next_rdata = 8'h00;
		unique case (addr)
			`GRS_A_CTRL: next_rdata = ctrl;
			`GRS_A_STB: next_rdata = stb | {1'b0, mss, 6'h00};
			`GRS_A_SRE: next_rdata = sre;
			`GRS_A_OUTQ: next_rdata = outq_empty ? 8'h00 : outq_data;
			`GRS_A_ERRQ: next_rdata = errq_empty ? 8'h00 : errq_data;
			`GRS_A_STATE: next_rdata = {3'b000, srq_lamp, listen_act, talk_act, rl};
			`GRS_A_COND0: next_rdata = cond_q[0];
			default: next_rdata = 8'h00;
		endcase
		for (int i = 0; i < NSETS; i++) begin
			if (is_event_addr(addr, i))
				next_rdata = event_r[i];
			if (is_enable_addr(addr, i))
				next_rdata = enable_r[i];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rdata <= 8'h00;
		else if (rd)
			rdata <= next_rdata;
	end

endmodule : grs_remote_status

// ===== dv/grs_remote_status_sva.sv
module grs_remote_status_sva
	import grs_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Watched ports
	input wire grs_bus_msg_t bus_msg,
	input wire logic ren_line,
	input wire logic srq_line,
	input wire logic [7:0] panel_keys_live,
	input wire grs_ind_t ind,
	input wire logic remote_state_indicator,
	input wire logic trigger,
	input wire logic input_flush,
	input wire logic deferred_cancel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_ren_gone;
		!ren_line [*2];
	endsequence
	property p_clear;
		bus_msg.dcl |-> input_flush && deferred_cancel;
	endproperty
	a_clear: assert property (p_clear) else $error("clear not flushed");
	property p_trig;
		trigger |-> $past(bus_msg.get && ind.listen);
	endproperty
	a_trig: assert property (p_trig) else $error("stray trigger");
	property p_rem_keys;
		ind.remote && $past(ind.remote) |-> panel_keys_live == 8'h00;
	endproperty
	a_rem_keys: assert property (p_rem_keys) else $error("keys live in remote");
	property p_llo_keys;
		ind.lockout && $past(ind.lockout) |-> panel_keys_live == 8'h00;
	endproperty
	a_llo_keys: assert property (p_llo_keys) else $error("keys live in lockout");
	property p_poll;
		bus_msg.spoll_read |-> ##[1:2] !srq_line;
	endproperty
	a_poll: assert property (p_poll) else $error("request kept after poll");
	property p_ren;
		s_ren_gone |-> ##1 !remote_state_indicator;
	endproperty
	a_ren: assert property (p_ren) else $error("remote without enable");
	property p_rem_entry;
		$rose(remote_state_indicator) |-> $past(bus_msg.my_listen && ren_line);
	endproperty
	a_rem_entry: assert property (p_rem_entry) else $error("remote not on listen");
	property p_talk_off;
		bus_msg.untalk || bus_msg.ifc || bus_msg.my_listen |-> ##2 !ind.talk;
	endproperty
	a_talk_off: assert property (p_talk_off) else $error("talk kept");
	property p_lsn_off;
		bus_msg.unlisten || bus_msg.ifc || bus_msg.my_talk |-> ##2 !ind.listen;
	endproperty
	a_lsn_off: assert property (p_lsn_off) else $error("listen kept");
endmodule : grs_remote_status_sva

bind grs_remote_status grs_remote_status_sva grs_remote_status_sva_inst (.*);

// ===== dv/grs_ctl_model.sv
module grs_ctl_model
	import grs_pkg::*;
(
	// Clock
	input wire logic clock,
	// Bus side
	input wire logic [7:0] poll_byte,
	output grs_bus_msg_t bus_msg,
	output logic ren_line
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bus_msg = '0;
		ren_line = 1'b0;
	end
	// One-cycle message, then idle so indicators settle
	task automatic send(input int i);
		@(posedge clock);
		bus_msg[i] <= 1'b1;
		@(posedge clock);
		bus_msg <= '0;
		repeat (3) @(posedge clock);
		#1;
	endtask : send
	task automatic set_ren(input logic v);
		@(posedge clock);
		ren_line <= v;
	endtask : set_ren
	// Whole poll byte; request flag is the bit of weight 64
	task automatic spoll(output logic [7:0] pb);
		pb = poll_byte;
		send(0);
	endtask : spoll
endmodule : grs_ctl_model

// ===== dv/grs_remote_status_tb.sv
module grs_remote_status_tb
	import grs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int M_TALK = 10;
	localparam int M_LSN = 9;
	localparam int M_UNT = 8;
	localparam int M_UNL = 7;
	localparam int M_IFC = 6;
	localparam int M_LLO = 5;
	localparam int M_GTL = 4;
	localparam int M_DCL = 3;
	localparam int M_SDC = 2;
	localparam int M_GET = 1;
	logic clock = 1'b0;
	logic rst = 1'b1;
	grs_bus_msg_t bus_msg;
	grs_ind_t ind;
	logic ren_line, srq_line, remote_state_indicator, listener_active_indicator;
	logic display_restore, trigger, input_flush, deferred_cancel, resp_full, err_full;
	logic [7:0] poll_byte, panel_keys_live, rdata, q;
	logic local_key = 1'b0, resp_push = 1'b0, err_push = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] panel_keys = 8'h5a, resp_data = 8'h00, err_data = 8'h00, wdata = 8'h00;
	logic [31:0] cond_in = 32'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] sb [4] = '{8'h20, 8'h01, 8'h08, 8'h80};
	int num_errors = 0, n_checks = 0, trig_n = 0, flush_n = 0, rest_n = 0;
	always #10 clock = ~clock;
	always @(posedge clock) begin
		trig_n += (trigger === 1'b1);
		flush_n += (input_flush === 1'b1);
		rest_n += (display_restore === 1'b1);
	end
	grs_remote_status grs_remote_status_inst (.*);
	grs_ctl_model grs_ctl_model_inst (.*);
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic w(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : w
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		check(nm, rdata, exp);
	endtask : reg_rd
	task automatic push(input logic e, input logic [7:0] d);
		@(posedge clock);
		err_push <= e;
		resp_push <= !e;
		err_data <= d;
		resp_data <= d;
		@(posedge clock);
		err_push <= 1'b0;
		resp_push <= 1'b0;
	endtask : push
	task automatic setc(input logic [31:0] d);
		@(posedge clock);
		cond_in <= d;
		w(3);
	endtask : setc
	task automatic press;
		@(posedge clock);
		local_key <= 1'b1;
		@(posedge clock);
		local_key <= 1'b0;
		w(3);
	endtask : press
	task automatic msg(input int i);
		grs_ctl_model_inst.send(i);
	endtask : msg
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		stop_test;
	end
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		for (int a = 0; a < 12; a++) reg_rd(a[3:0], 8'h00, "reset");
		reg_rd(4'he, 8'h00, "state");
		msg(M_LSN);
		check("no ren", remote_state_indicator, 1'b0);
		check("listener_active_indicator", listener_active_indicator, 1'b1);
		grs_ctl_model_inst.set_ren(1'b1);
		w(3);
		check("ren only", remote_state_indicator, 1'b0);
		msg(M_LSN);
		check("remote", remote_state_indicator, 1'b1);
		check("keys rem", panel_keys_live, 8'h00);
		press;
		check("local", remote_state_indicator, 1'b0);
		check("keys loc", panel_keys_live, 8'h5a);
		msg(M_LSN);
		msg(M_LLO);
		press;
		check("locked", {ind.lockout, remote_state_indicator}, 8'h03);
		msg(M_GTL);
		check("gtl", {ind.lockout, remote_state_indicator}, 8'h00);
		check("keys gtl", panel_keys_live, 8'h5a);
		check("restore", rest_n[7:0], 8'h01);
		msg(M_TALK);
		check("talk", {ind.talk, ind.listen}, 8'h02);
		msg(M_LSN);
		check("listen", {ind.talk, ind.listen}, 8'h01);
		msg(M_GET);
		reg_wr(4'h0, 8'h01);
		msg(M_GET);
		msg(M_SDC);
		msg(M_UNL);
		msg(M_GET);
		msg(M_SDC);
		msg(M_DCL);
		check("trig", trig_n[7:0], 8'h01);
		check("flush", flush_n[7:0], 8'h02);
		msg(M_TALK);
		msg(M_UNT);
		check("untalk", {ind.talk, ind.listen}, 8'h00);
		msg(M_LSN);
		msg(M_IFC);
		check("ifc", {ind.talk, ind.listen}, 8'h00);
		grs_ctl_model_inst.set_ren(1'b0);
		w(3);
		check("ren off", remote_state_indicator, 1'b0);
		reg_wr(4'h2, 8'h20);
		setc(32'h01);
		reg_rd(4'h3, 8'h01, "cond");
		reg_rd(4'h1, 8'h00, "masked");
		setc(32'h0);
		reg_rd(4'h3, 8'h00, "cond low");
		reg_wr(4'h8, 8'h01);
		w(3);
		check("srq", srq_line, 1'b1);
		check("srq lamp", ind.srq, 1'b1);
		reg_rd(4'h1, 8'h60, "mss");
		grs_ctl_model_inst.spoll(q);
		check("poll rq", q[6], 1'b1);
		check("poll byte", q, 8'h60);
		check("srq off", srq_line, 1'b0);
		check("poll after", poll_byte, 8'h20);
		reg_rd(4'h1, 8'h60, "mss kept");
		reg_wr(4'h2, 8'h21);
		reg_wr(4'h9, 8'h01);
		setc(32'h100);
		check("srq again", srq_line, 1'b1);
		reg_rd(4'h4, 8'h01, "event");
		reg_rd(4'h4, 8'h00, "event rd");
		reg_rd(4'h8, 8'h01, "enable");
		setc(32'h0);
		reg_wr(4'hf, 8'h01);
		reg_wr(4'h2, 8'h00);
		for (int s = 0; s < 4; s++) begin
			reg_wr(4'h8 + s[3:0], 8'h01);
			setc(32'h1 << (8 * s));
			reg_rd(4'h1, sb[s], "set sum");
			setc(32'h0);
			reg_wr(4'hf, 8'h01);
			reg_rd(4'h1, 8'h00, "cls");
		end
		reg_wr(4'hf, 8'h02);
		reg_rd(4'h9, 8'h00, "preset");
		reg_rd(4'h8, 8'h01, "ese kept");
		reg_wr(4'h8, 8'h00);
		reg_rd(4'h8, 8'h00, "ese zero");
		for (int i = 0; i < 11; i++) push(1'b1, i[7:0]);
		w(1);
		check("err full", err_full, 1'b1);
		reg_rd(4'h1, 8'h04, "eav");
		for (int i = 0; i < 10; i++) reg_rd(4'hd, i[7:0], "errq");
		reg_rd(4'h1, 8'h00, "eav off");
		push(1'b0, 8'ha1);
		push(1'b0, 8'hb2);
		for (int i = 0; i < 15; i++) push(1'b0, 8'hc0 + i[7:0]);
		w(1);
		check("out full", resp_full, 1'b1);
		reg_wr(4'ha, 8'h11);
		reg_rd(4'h1, 8'h10, "mav");
		reg_rd(4'hc, 8'ha1, "outq");
		msg(M_DCL);
		reg_rd(4'h1, 8'h00, "dcl");
		reg_rd(4'ha, 8'h11, "dcl keeps");
		check("out flushed", resp_full, 1'b0);
		reg_rd(4'hc, 8'h00, "outq empty");
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		reg_rd(4'ha, 8'h00, "enable rst");
		reg_rd(4'he, 8'h00, "state rst");
		stop_test;
	end
endmodule : grs_remote_status_tb
